// ===== drv_pkg.sv
// package: constants and carriers for the serial driver control interface
package drv_pkg;
  localparam int WordBits = 16;
  localparam int NumOut = 12;
  localparam int BitClear = 0;
  localparam int BitOutLo = 1;
  localparam int BitOpenLoadN = 13;
  localparam int BitShortDelay = 14;
  localparam int BitRun = 15;
  localparam int StTempWarn = 0;
  localparam int StShort = 13;
  localparam int StStandby = 14;
  localparam int StSupplyFail = 15;
  // control word after reset: run, long delay, open-load detection off, outputs off
  localparam logic [15:0] ControlReset = 16'he000;
  localparam logic [4:0] BitCountMax = 5'h10;

  typedef struct packed {
    logic select;
    logic sclk;
    logic serialIn;
  } link_in_s;

  typedef struct packed {
    logic tempWarn;
    logic overTemp;
    logic underVolt;
    logic inhibitPin;
    logic [11:0] openLoad;
    logic [11:0] shortDet;
  } analog_s;
endpackage

// ===== sync2.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] metaReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      metaReg <= '0;
      syncOut <= '0;
    end else begin
      metaReg <= asyncIn;
      syncOut <= metaReg;
    end
  end
endmodule

// ===== serial_driver_control_interface.sv
// serial control/status interface of a twelve-channel output driver
`timescale 1ns/1ps
module serial_driver_control_interface
  import drv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link from the controller
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // digital flags from the analog protection
  input wire logic tempWarn,
  input wire logic overTemp,
  input wire logic underVolt,
  input wire logic inhibitN,
  input wire logic [11:0] openLoad,
  input wire logic [11:0] shortDet,
  // driver controls
  output logic [11:0] outputOn,
  output logic openLoadEnable,
  output logic longShortDelay,
  output logic [15:0] controlWord
);
  link_in_s linkRaw, link;
  analog_s anaRaw, ana;
  logic selPrev, clkPrev;
  logic [15:0] shiftIn, shiftOut;
  logic [4:0] bitCount;
  logic [11:0] shortOff;
  logic shutdownReg, supplyFailReg, shortFlagReg;
  logic selFall, selRise, clkFall, clkRise, wordDone, clearReq;
  logic [15:0] statusNow, newWord;
  logic standbyNow;

  assign linkRaw = '{select: selectN, sclk: serialClk, serialIn: serialIn};
  assign anaRaw = '{tempWarn: tempWarn, overTemp: overTemp, underVolt: underVolt,
                    inhibitPin: inhibitN, openLoad: openLoad, shortDet: shortDet};

  sync2 #(.W(3)) uSyncLink (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(linkRaw),
    .syncOut(link)
  );

  sync2 #(.W(28)) uSyncAna (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(anaRaw),
    .syncOut(ana)
  );

  // edge detection on synchronised pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // the synchroniser resets low, so start low too or a false select fall follows reset
      selPrev <= 1'b0;
      clkPrev <= 1'b0;
    end else begin
      selPrev <= link.select;
      clkPrev <= link.sclk;
    end
  end

  assign selFall = selPrev && !link.select;
  assign selRise = !selPrev && link.select;
  assign clkFall = !link.select && clkPrev && !link.sclk;
  assign clkRise = !link.select && !clkPrev && link.sclk;
  assign wordDone = (bitCount >= BitCountMax);
  assign newWord = shiftIn;
  assign clearReq = selRise && wordDone && newWord[BitClear];

  // receive shifter: LSB arrives first so bits enter from the top
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn <= '0;
      bitCount <= '0;
    end else if (selFall) begin
      bitCount <= '0;
    end else if (clkFall) begin
      shiftIn <= {link.serialIn, shiftIn[15:1]};
      if (!wordDone) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end

  // control word updates only on select rising after a full word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controlWord <= ControlReset;
    end else if (selRise && wordDone) begin
      controlWord <= newWord;
    end
  end

  assign standbyNow = !controlWord[BitRun] || !ana.inhibitPin;

  // sticky fault state; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdownReg <= 1'b0;
      supplyFailReg <= 1'b0;
      shortOff <= '0;
    end else begin
      shutdownReg <= ana.overTemp || (shutdownReg && !clearReq);
      supplyFailReg <= ana.underVolt || (supplyFailReg && !clearReq);
      shortOff <= (ana.shortDet & outputOn) | (clearReq ? 12'h000 : shortOff);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shortFlagReg <= 1'b0;
    end else begin
      shortFlagReg <= (|(ana.shortDet & outputOn)) || (shortFlagReg && !clearReq);
    end
  end

  // status assembly
  always_comb begin
    statusNow = '0;
    statusNow[StTempWarn] = ana.tempWarn;
    for (int i = 0; i < NumOut; i++) begin
      if (!controlWord[BitOpenLoadN] && !controlWord[BitOutLo + i]) begin
        statusNow[BitOutLo + i] = ana.openLoad[i];
      end else begin
        statusNow[BitOutLo + i] = outputOn[i];
      end
    end
    statusNow[StShort] = shortFlagReg;
    statusNow[StStandby] = standbyNow;
    statusNow[StSupplyFail] = supplyFailReg;
    if (shutdownReg) begin
      statusNow = 16'hffff;
    end
  end

  // transmit: snapshot on select falling, next bit on each rising clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftOut <= '0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (selFall) begin
      shiftOut <= {1'b0, statusNow[15:1]};
      serialOut <= statusNow[StTempWarn];
      serialOutEn <= 1'b1;
    end else if (link.select) begin
      serialOutEn <= 1'b0;
    end else if (clkRise) begin
      serialOut <= shiftOut[0];
      shiftOut <= {1'b0, shiftOut[15:1]};
    end
  end

  // output stage drive; serial side is untouched by standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outputOn <= '0;
      openLoadEnable <= !ControlReset[BitOpenLoadN];
      longShortDelay <= ControlReset[BitShortDelay];
    end else begin
      if (standbyNow || shutdownReg || ana.underVolt) begin
        outputOn <= '0;
      end else begin
        outputOn <= controlWord[12:1] & ~shortOff & ~ana.shortDet;
      end
      openLoadEnable <= !controlWord[BitOpenLoadN];
      longShortDelay <= controlWord[BitShortDelay];
    end
  end

  // checks are gathered after all the logic at the end of the module; all stay quiet while reset is held
  a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(selRise && wordDone) |=> controlWord == $past(controlWord))
    else $error("control word changed without a completed transfer");

  a_ctrl_load: assert property (@(posedge clk) disable iff (!rst_n)
    selRise && wordDone |=> controlWord == $past(shiftIn))
    else $error("control word is not the last sixteen bits received");

  a_shift_lsb: assert property (@(posedge clk) disable iff (!rst_n)
    clkFall && !selFall |=> shiftIn[15] == $past(link.serialIn))
    else $error("received bit not entered at the top of the shifter");

  a_shift_count: assert property (@(posedge clk) disable iff (!rst_n)
    clkFall && !selFall && !wordDone |=> bitCount == $past(bitCount) + 5'h01)
    else $error("falling serial clock not counted");

  a_dout_release: assert property (@(posedge clk) disable iff (!rst_n)
    link.select && !selRise |=> !serialOutEn)
    else $error("serial output driven while deselected");

  a_first_bit: assert property (@(posedge clk) disable iff (!rst_n)
    selFall |=> serialOut == $past(statusNow[0]) && serialOutEn)
    else $error("first status bit wrong");

  a_snapshot_load: assert property (@(posedge clk) disable iff (!rst_n)
    selFall |=> shiftOut == ($past(statusNow) >> 1))
    else $error("status snapshot not loaded at select fall");

  a_dout_shift: assert property (@(posedge clk) disable iff (!rst_n)
    clkRise && !selFall |=> serialOut == $past(shiftOut[0]))
    else $error("serial output did not move on at rising clock");

  a_dout_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !link.select && !selFall && !clkRise |=> $stable(serialOut))
    else $error("serial output changed between rising clocks");

  a_overtemp_all: assert property (@(posedge clk) disable iff (!rst_n)
    shutdownReg |-> statusNow == 16'hffff)
    else $error("shutdown status not all ones");

  a_shutdown_set: assert property (@(posedge clk) disable iff (!rst_n)
    ana.overTemp |=> shutdownReg)
    else $error("overtemperature did not enter shutdown");

  a_clear_flags: assert property (@(posedge clk) disable iff (!rst_n)
    clearReq && !ana.underVolt && !ana.overTemp |=> !supplyFailReg && !shutdownReg)
    else $error("status clear left supply fail or shutdown set");

  a_supply_set: assert property (@(posedge clk) disable iff (!rst_n)
    ana.underVolt |=> supplyFailReg)
    else $error("undervoltage not flagged");

  a_supply_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    supplyFailReg && !clearReq |=> supplyFailReg)
    else $error("supply fail cleared without status clear");

  a_short_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ana.shortDet & outputOn) != 12'h000 |=> shortFlagReg)
    else $error("short on a driven output not flagged");

  a_short_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    shortFlagReg && !clearReq |=> shortFlagReg)
    else $error("short flag cleared without status clear");

  a_clear_short: assert property (@(posedge clk) disable iff (!rst_n)
    clearReq && (ana.shortDet & outputOn) == 12'h000 |=> !shortFlagReg && shortOff == 12'h000)
    else $error("status clear did not release shorted outputs");

  a_shorted_off: assert property (@(posedge clk) disable iff (!rst_n)
    shortOff != 12'h000 |=> (outputOn & $past(shortOff)) == 12'h000)
    else $error("shorted output driven again before status clear");

  a_standby_off: assert property (@(posedge clk) disable iff (!rst_n)
    standbyNow |=> outputOn == 12'h000)
    else $error("outputs on during standby");

  a_inhibit_off: assert property (@(posedge clk) disable iff (!rst_n)
    !ana.inhibitPin |=> outputOn == 12'h000)
    else $error("outputs on while inhibit pin is low");

  a_shutdown_off: assert property (@(posedge clk) disable iff (!rst_n)
    shutdownReg |=> outputOn == 12'h000)
    else $error("outputs on during shutdown");

  a_out_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !standbyNow && !shutdownReg && !ana.underVolt && shortOff == 12'h000 && ana.shortDet == 12'h000
      |=> outputOn == $past(controlWord[12:1]))
    else $error("outputs not following control bits");

  a_standby_bit: assert property (@(posedge clk) disable iff (!rst_n)
    !shutdownReg |-> statusNow[14] == (!controlWord[15] || !ana.inhibitPin))
    else $error("standby status mismatch");

  a_status_on: assert property (@(posedge clk) disable iff (!rst_n)
    !shutdownReg && controlWord[13] |-> statusNow[12:1] == outputOn)
    else $error("status does not show output state");

  a_open_enable: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 openLoadEnable == !$past(controlWord[13]))
    else $error("open-load enable not following control");

  a_delay_sel: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 longShortDelay == $past(controlWord[14]))
    else $error("delay select not following control");
endmodule

// ===== spi_ctrl_model.sv
// controller-side model of the serial link: drives select, clock and data
`timescale 1ns/1ps
module spi_ctrl_model (
  // link pins
  output logic selectN,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  logic [15:0] rxWord;
  event done;
  // clock idles low and data rests at its pull-down level between frames
  initial begin
    selectN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // 64 ns link period, kept 3 ns after the rising system clock edges
  task automatic xfer(input logic [31:0] w, input int n);
    #3 selectN = 1'b0;
    #64;
    for (int i = 0; i < n; i++) begin
      // read each bit just before the rise that would move it on
      if (i < 16) rxWord[i] = serialOutEn ? serialOut : 1'bx;
      serialIn = w[i];
      serialClk = 1'b1;
      #32 serialClk = 1'b0;
      #32;
    end
    serialIn = 1'b0;
    #32 selectN = 1'b1;
    ->done;
  endtask
endmodule

// ===== tb_top.sv
// self-checking testbench for the serial driver control interface
`timescale 1ns/1ps
module tb_top
  import drv_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, tempWarn = 1'b0, overTemp = 1'b0, underVolt = 1'b0, inhibitN = 1'b1;
  logic [11:0] openLoad = 12'h000, shortDet = 12'h000, outputOn;
  logic selectN, serialClk, serialIn, serialOut, serialOutEn, openLoadEnable, longShortDelay;
  logic [15:0] controlWord, cur = 16'he000;
  logic [31:0] w;
  logic [63:0] e;
  logic [63:0] expQ[$];
  int err_total = 0, comparisons = 0, seed = 82122;

  initial forever #4 clk = ~clk;

  serial_driver_control_interface dut (.clk(clk), .rst_n(rst_n), .selectN(selectN), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .tempWarn(tempWarn),
    .overTemp(overTemp), .underVolt(underVolt), .inhibitN(inhibitN), .openLoad(openLoad),
    .shortDet(shortDet), .outputOn(outputOn), .openLoadEnable(openLoadEnable),
    .longShortDelay(longShortDelay), .controlWord(controlWord));
  spi_ctrl_model ctrl (.selectN(selectN), .serialClk(serialClk), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn));

  // status in normal operation; on/off shows unless detection is on for an off output
  function automatic logic [15:0] stat(logic [15:0] c);
    return {1'b0, ~c[15] | ~inhibitN, 1'b0, c[12:1] | (openLoad & ~c[12:1] & {12{~c[13]}}), tempWarn};
  endfunction

  task automatic cmp(string nm, logic [15:0] ex, logic [15:0] got, logic [15:0] m);
    comparisons++;
    if ((got & m) !== (ex & m)) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex & m, got & m);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // keep masks the outputs expected to stay driven after the write
  task automatic op(string nm, logic [31:0] wd, int n, logic [15:0] se, logic [15:0] sm, logic [15:0] cw,
                    logic [11:0] keep);
    expQ.push_back({se, sm, cw, 2'b00, ~cw[13], cw[14], cw[12:1] & keep & {12{cw[15]}}});
    ctrl.xfer(wd, n);
    repeat (12) @(posedge clk);
    cur = cw;
    $display("test %s done", nm);
  endtask

  task automatic pulse(int which);
    @(posedge clk);
    if (which == 0) underVolt <= 1'b1;
    else if (which == 1) overTemp <= 1'b1;
    else shortDet <= 12'h008;
    repeat (20) @(posedge clk);
    {underVolt, overTemp, shortDet} <= '0;
    repeat (12) @(posedge clk);
  endtask

  initial forever begin
    @(ctrl.done);
    e = expQ.pop_front();
    cmp("status", e[63:48], ctrl.rxWord, e[47:32]);
    repeat (8) @(posedge clk);
    cmp("control", e[31:16], controlWord, 16'hffff);
    cmp("drive", e[15:0], {serialOutEn, 1'b0, openLoadEnable, longShortDelay, outputOn}, 16'hffff);
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("reset word", ControlReset, controlWord, 16'hffff);
    for (int k = 0; k < 6; k++) begin
      w = $random(seed);
      tempWarn <= w[0];
      openLoad <= w[12:1];
      repeat (8) @(posedge clk);
      w = $random(seed) | 32'h8000;
      w[0] = 1'b0;
      op("random", w, 16, stat(cur), 16'hffff, w[15:0], 12'hfff);
    end
    op("abort", $random(seed), 5, {15'h0, tempWarn}, 16'h0001, cur, 12'hfff);
    w = $random(seed) | 32'h80110;
    w[4] = 1'b0;
    op("extra bits", w, 20, stat(cur), 16'hffff, w[19:4], 12'hfff);
    inhibitN <= 1'b0;
    repeat (8) @(posedge clk);
    op("pin inhibit", cur, 16, 16'h4000, 16'h4000, cur, 12'h000);
    inhibitN <= 1'b1;
    // let the pin settle through the synchroniser and the outputs come back first
    repeat (8) @(posedge clk);
    op("soft standby", cur & 16'h7fff, 16, stat(cur), 16'hffff, cur & 16'h7fff, 12'hfff);
    op("standby flag", cur | 16'h8000, 16, stat(cur), 16'h4001, cur | 16'h8000, 12'hfff);
    pulse(0);
    op("supply fail", cur, 16, 16'h8000, 16'h8000, cur, 12'hfff);
    op("supply held", cur | 16'h1, 16, 16'h8000, 16'h8000, cur | 16'h1, 12'hfff);
    op("supply clear", cur & 16'hfffe, 16, stat(cur), 16'hffff, cur & 16'hfffe, 12'hfff);
    pulse(1);
    op("shutdown", cur, 16, 16'hffff, 16'hffff, cur, 12'h000);
    op("shutdown clr", cur | 16'h1, 16, 16'hffff, 16'hffff, cur | 16'h1, 12'hfff);
    op("after clear", cur & 16'hfffe, 16, stat(cur), 16'hffff, cur & 16'hfffe, 12'hfff);
    pulse(2);
    op("short", cur, 16, 16'h2000, 16'h2000, cur, 12'hff7);
    op("short clr", cur | 16'h1, 16, 16'h2000, 16'h2000, cur | 16'h1, 12'hfff);
    op("short gone", cur & 16'hfffe, 16, stat(cur), 16'hffff, cur & 16'hfffe, 12'hfff);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
